// File: caf_host_map.vh
// Notes on behaviour
// [RULE1] Filter lookup RAM is 512 words of 32 bits
// [RULE2] RAM holds 1024 standard or 512 extended identifiers
// [RULE3] Standard entries ascending, two per word, controller 1-6
// [RULE4] Standard range word holds ascending inclusive bounds
// [RULE5] While filtering, range words written all zero or ones
// [RULE6] Extended use needs a non-empty extended table
// [RULE7] Extended range table holds an even entry count
// [RULE8] Auto-store never applies to extended identifiers
// [RULE9] Tables consecutive, last ends at tables end
// [RULE10] Table empty when start equals next start
// [RULE11] Controller signals filter with complete identifier
// [RULE12] Auto-store table, then single table searched
// [RULE13] Single-table miss falls through to range table
// [RULE14] Miss in both tables discards the message
// [RULE15] Filter off bit resets to one, ignores all
// [RULE16] Bypass set before address or RAM changes
// [RULE17] Off and bypass clear means screening active
// [RULE18] Auto-store enable makes filter store messages
// [RULE19] Single standard start in bits 10:2, rest zero
// [RULE20] Standard range start at most 0x800
// [RULE21] Single extended start at most 0x800
// [RULE22] Standard use needs a non-empty standard table
// [RULE23] Error flag cleared by reading error address
// [RULE24] Auto-stored message at tables end plus index*12
// [RULE25] Simultaneous requests served one at a time
`ifndef CAF_HOST_MAP_VH
`define CAF_HOST_MAP_VH
// ==========================================================
// Filter register map (byte addresses on the device bus)
`define CAF_FILTER_MODE     32'he003c000
`define CAF_STD_SINGLE      32'he003c004
`define CAF_STD_RANGE       32'he003c008
`define CAF_EXT_SINGLE      32'he003c00c
`define CAF_EXT_RANGE       32'he003c010
`define CAF_TABLES_END      32'he003c014
`define CAF_ERR_ADDR        32'he003c018
`define CAF_ERR_FLAG        32'he003c01c
// Mode bit positions and values
`define CAF_BIT_OFF         0
`define CAF_BIT_BYPASS      1
`define CAF_BIT_AUTO        2
`define CAF_MODE_RESET      3'h1
// Address field masks and limits
`define CAF_MASK_10_2       12'h7fc
`define CAF_MASK_11_2       12'hffc
`define CAF_ADDR_LIMIT      14'h0800
`define CAF_AUTO_BYTES      14'h0006
`define CAF_WORD_ALL_ONES   32'hffffffff
// ==========================================================
// Host register offsets (software side)
`define CAF_H_CMD           8'h00
`define CAF_H_MODE          8'h04
`define CAF_H_SSA           8'h08
`define CAF_H_RSA           8'h0c
`define CAF_H_ESA           8'h10
`define CAF_H_ERSA          8'h14
`define CAF_H_END           8'h18
`define CAF_H_RIDX          8'h1c
`define CAF_H_RDAT          8'h20
`define CAF_H_STAT          8'h24
`define CAF_H_ERRAD         8'h28
// Command codes
`define CAF_OP_CFG          3'h1
`define CAF_OP_RAM          3'h2
`define CAF_OP_ENA          3'h3
`define CAF_OP_DIS          3'h4
`define CAF_OP_ERR          3'h5
`endif

// File: caf_host.v
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "caf_host_map.vh"
module caf_host #(
  parameter [31:0] RAM_BASE = 32'h00010000  // Lookup RAM window base
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  sw_addr,
  input  wire [31:0] sw_wdata,
  input  wire        sw_wr,
  input  wire        sw_rd,
  output reg  [31:0] sw_rdata,
  output reg  [31:0] dev_addr,
  output reg  [31:0] dev_wdata,
  output reg         dev_wr,
  output reg         dev_rd,
  input  wire [31:0] dev_rdata
);

  // ========================================================
  // States
  localparam [1:0] ST_IDLE = 2'd0;  // Waiting for a command
  localparam [1:0] ST_RUN  = 2'd1;  // Issuing one bus step
  localparam [1:0] ST_RW1  = 2'd2;  // Read strobe cycle
  localparam [1:0] ST_RW2  = 2'd3;  // Read data cycle

  // ========================================================
  // Host registers
  reg  [4:0]  hmode;     // [2:0] mode, [3] std used, [4] ext used
  reg  [11:0] ssa;       // Single standard start
  reg  [11:0] rsa;       // Standard range start
  reg  [11:0] esa;       // Single extended start
  reg  [11:0] ersa;      // Extended range start
  reg  [11:0] tend;      // Tables end
  reg  [8:0]  ridx;      // RAM word index
  reg  [31:0] rdat;      // RAM word data
  reg  [2:0]  dev_mode;  // Mode the filter holds between commands
  reg         refused;   // Last command refused
  reg         err_seen;  // Table error flag as last read
  reg  [11:0] err_addr;  // Offending RAM address as last read
  reg  [1:0]  state;     // Sequencer state
  reg  [2:0]  op;        // Command in progress
  reg  [2:0]  step;      // Step within command

  // ========================================================
  // Per-step bus request, combinational
  reg  [31:0] st_addr;   // Address of this step
  reg  [31:0] st_data;   // Write data of this step
  reg         st_read;   // Step is a read
  reg         st_last;   // Step ends the command
  wire [2:0]  mode_bp;   // Current mode with bypass forced

  assign mode_bp = dev_mode | (3'h1 << `CAF_BIT_BYPASS);

  // Word index to byte address inside the RAM window
  function [31:0] ram_byte;
    input [8:0] idx;
    begin
      ram_byte = RAM_BASE + {21'h0, idx, 2'b00};
    end
  endfunction

  // Step table of each command
  always @* begin
    st_addr = `CAF_FILTER_MODE;
    st_data = 32'h0;
    st_read = 1'b0;
    st_last = 1'b0;
    case (op)
      `CAF_OP_CFG: begin
        // Bypass first, then boundaries, then final mode
        case (step)
          3'd0: st_data = {29'h0, mode_bp};  // RULE16
          3'd1: begin
            st_addr = `CAF_STD_SINGLE;
            st_data = {20'h0, ssa & `CAF_MASK_10_2};  // RULE19
          end
          3'd2: begin
            st_addr = `CAF_STD_RANGE;
            st_data = {20'h0, rsa & `CAF_MASK_11_2};
          end
          3'd3: begin
            st_addr = `CAF_EXT_SINGLE;
            st_data = {20'h0, esa & `CAF_MASK_10_2};
          end
          3'd4: begin
            st_addr = `CAF_EXT_RANGE;
            st_data = {20'h0, ersa & `CAF_MASK_11_2};
          end
          3'd5: begin
            st_addr = `CAF_TABLES_END;
            st_data = {20'h0, tend & `CAF_MASK_11_2};
          end
          default: begin
            st_data = {29'h0, hmode[2:0]};
            st_last = 1'b1;
          end
        endcase
      end
      `CAF_OP_RAM: begin
        // A single RAM word write is wrapped in bypass
        case (step)
          3'd0: st_data = {29'h0, mode_bp};  // RULE16
          3'd1: begin
            st_addr = ram_byte(ridx);
            st_data = rdat;  // RULE3
          end
          default: begin
            st_data = {29'h0, dev_mode};
            st_last = 1'b1;
          end
        endcase
      end
      `CAF_OP_ENA, `CAF_OP_DIS: begin
        // Whole word goes to all zeros or all ones, so no bypass is needed
        st_addr = ram_byte(ridx);
        st_data = (op == `CAF_OP_DIS) ? `CAF_WORD_ALL_ONES
                                      : 32'h0;  // RULE5
        st_last = 1'b1;
      end
      default: begin
        // Flag first; reading the address clears it
        st_read = 1'b1;
        if (step == 3'd0) begin
          st_addr = `CAF_ERR_FLAG;
        end else begin
          st_addr = `CAF_ERR_ADDR;  // RULE23
          st_last = 1'b1;
        end
      end
    endcase
  end

  // ========================================================
  // Command acceptance checks
  reg         cfg_ok;    // Boundaries form a legal table layout
  reg         idx_ok;    // Index lies in the standard range table
  wire [11:0] ssa_m;     // Masked boundaries
  wire [11:0] rsa_m;
  wire [11:0] esa_m;
  wire [11:0] ersa_m;
  wire [11:0] end_m;
  wire [11:0] ridx_b;    // Index as a byte address
  wire [13:0] auto_top;  // End plus auto-store area

  assign ssa_m    = ssa & `CAF_MASK_10_2;
  assign rsa_m    = rsa & `CAF_MASK_11_2;
  assign esa_m    = esa & `CAF_MASK_10_2;
  assign ersa_m   = ersa & `CAF_MASK_11_2;
  assign end_m    = tend & `CAF_MASK_11_2;
  assign ridx_b   = {1'b0, ridx, 2'b00};
  // Six bytes per table byte, twelve per halfword identifier
  assign auto_top = {2'b00, end_m} + {2'b00, ssa_m} * `CAF_AUTO_BYTES;

  always @* begin
    cfg_ok = 1'b1;
    // Consecutive tables ending at the tables end
    if (ssa_m > rsa_m || rsa_m > esa_m || esa_m > ersa_m ||
        ersa_m > end_m) begin
      cfg_ok = 1'b0;  // RULE9
    end
    if ({2'b00, rsa_m} > `CAF_ADDR_LIMIT) begin
      cfg_ok = 1'b0;  // RULE20
    end
    if ({2'b00, esa_m} > `CAF_ADDR_LIMIT ||
        {2'b00, end_m} > `CAF_ADDR_LIMIT) begin
      cfg_ok = 1'b0;  // RULE21
    end
    // Extended ranges are pairs of words
    if (end_m[2] != ersa_m[2]) begin
      cfg_ok = 1'b0;  // RULE7
    end
    // Standard use needs one non-empty standard table
    if (hmode[3] && !((hmode[`CAF_BIT_AUTO] && ssa_m != 12'h0) ||
        ssa_m != rsa_m || rsa_m != esa_m)) begin
      cfg_ok = 1'b0;  // RULE22 RULE10
    end
    // Extended use needs one non-empty extended table
    if (hmode[4] && esa_m == end_m) begin
      cfg_ok = 1'b0;  // RULE6 RULE10
    end
    // Auto-store area must fit below the RAM top
    if (hmode[`CAF_BIT_AUTO] && auto_top > `CAF_ADDR_LIMIT) begin
      cfg_ok = 1'b0;  // RULE24
    end
  end

  // Disable toggling only hits standard range words
  always @* begin
    idx_ok = (ridx_b >= rsa_m) && (ridx_b < esa_m);  // RULE4
  end

  // ========================================================
  // Software writes and command start
  wire       cmd_wr;     // Write to the command register
  wire [2:0] cmd_op;     // Requested command
  wire       cmd_ok;     // Request passes its checks

  assign cmd_wr = sw_wr && (sw_addr == `CAF_H_CMD);
  assign cmd_op = sw_wdata[2:0];
  assign cmd_ok = (cmd_op == `CAF_OP_CFG) ? cfg_ok :
                  (cmd_op == `CAF_OP_RAM) ? 1'b1 :
                  (cmd_op == `CAF_OP_ENA ||
                   cmd_op == `CAF_OP_DIS) ? idx_ok :
                  (cmd_op == `CAF_OP_ERR);

  // Settings are frozen while a command runs
  always @(posedge clk) begin
    if (!rst_n) begin
      hmode <= {2'b00, `CAF_MODE_RESET};  // RULE15
      ssa   <= 12'h0;
      rsa   <= 12'h0;
      esa   <= 12'h0;
      ersa  <= 12'h0;
      tend  <= 12'h0;
      ridx  <= 9'h0;
      rdat  <= 32'h0;
    end else if (sw_wr && state == ST_IDLE) begin
      if (sw_addr == `CAF_H_MODE) begin
        hmode <= sw_wdata[4:0];
      end else if (sw_addr == `CAF_H_SSA) begin
        ssa <= sw_wdata[11:0];
      end else if (sw_addr == `CAF_H_RSA) begin
        rsa <= sw_wdata[11:0];
      end else if (sw_addr == `CAF_H_ESA) begin
        esa <= sw_wdata[11:0];
      end else if (sw_addr == `CAF_H_ERSA) begin
        ersa <= sw_wdata[11:0];
      end else if (sw_addr == `CAF_H_END) begin
        tend <= sw_wdata[11:0];
      end else if (sw_addr == `CAF_H_RIDX) begin
        ridx <= sw_wdata[8:0];
      end else if (sw_addr == `CAF_H_RDAT) begin
        rdat <= sw_wdata;
      end
    end
  end

  // ========================================================
  // Bus sequencer toward the filter
  always @(posedge clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      op        <= 3'h0;
      step      <= 3'h0;
      dev_addr  <= 32'h0;
      dev_wdata <= 32'h0;
      dev_wr    <= 1'b0;
      dev_rd    <= 1'b0;
      dev_mode  <= `CAF_MODE_RESET;  // RULE15
      refused   <= 1'b0;
      err_seen  <= 1'b0;
      err_addr  <= 12'h0;
    end else begin
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Commands while busy are dropped
          if (cmd_wr) begin
            refused <= !cmd_ok;
            if (cmd_ok) begin
              op    <= cmd_op;
              step  <= 3'h0;
              state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          // One bus access per step
          dev_addr  <= st_addr;
          dev_wdata <= st_data;
          dev_wr    <= !st_read;
          dev_rd    <= st_read;
          if (st_read) begin
            state <= ST_RW1;
          end else if (st_last) begin
            state <= ST_IDLE;
            if (op == `CAF_OP_CFG) begin
              dev_mode <= hmode[2:0];  // RULE17 RULE18
            end
          end else begin
            step <= step + 3'h1;
          end
        end
        ST_RW1: begin
          // Data stands in the following cycle
          state <= ST_RW2;
        end
        default: begin
          if (step == 3'h0) begin
            err_seen <= dev_rdata[0];
            step     <= 3'h1;
            state    <= ST_RUN;
          end else begin
            err_addr <= dev_rdata[11:0] & `CAF_MASK_10_2;
            state    <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ========================================================
  // Software read port, data one cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      sw_rdata <= 32'h0;
    end else if (sw_rd) begin
      if (sw_addr == `CAF_H_MODE) begin
        sw_rdata <= {27'h0, hmode};
      end else if (sw_addr == `CAF_H_SSA) begin
        sw_rdata <= {20'h0, ssa};
      end else if (sw_addr == `CAF_H_RSA) begin
        sw_rdata <= {20'h0, rsa};
      end else if (sw_addr == `CAF_H_ESA) begin
        sw_rdata <= {20'h0, esa};
      end else if (sw_addr == `CAF_H_ERSA) begin
        sw_rdata <= {20'h0, ersa};
      end else if (sw_addr == `CAF_H_END) begin
        sw_rdata <= {20'h0, tend};
      end else if (sw_addr == `CAF_H_RIDX) begin
        sw_rdata <= {23'h0, ridx};
      end else if (sw_addr == `CAF_H_RDAT) begin
        sw_rdata <= rdat;
      end else if (sw_addr == `CAF_H_STAT) begin
        sw_rdata <= {26'h0, dev_mode, err_seen, refused,
                     state != ST_IDLE};
      end else if (sw_addr == `CAF_H_ERRAD) begin
        sw_rdata <= {20'h0, err_addr};
      end else begin
        // Unmapped offsets read as zero
        sw_rdata <= 32'h0;
      end
    end
  end

endmodule // caf_host

// File: caf_dev_model.sv
`timescale 1ns/1ps
`include "caf_host_map.vh"
// ==========================================
// Filter device model on the far side
module caf_dev_model #(
  parameter [31:0] RAM_BASE = 32'h00010000  // Lookup RAM window base
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [31:0] dev_addr,
  input  wire [31:0] dev_wdata,
  input  wire        dev_wr,
  input  wire        dev_rd,
  output reg  [31:0] dev_rdata,
  input  wire        err_set,
  input  wire [31:0] err_at
);
  reg  [31:0] ram [0:511];  // Lookup words
  reg  [31:0] regs [0:5];   // Mode, four starts, tables end
  reg         err_flag;     // Table content fault seen
  reg  [31:0] err_addr;     // Where the fault was seen
  wire [31:0] off    = dev_addr - RAM_BASE;
  wire        in_ram = off < 32'h800;
  wire        in_reg = (dev_addr & 32'hffffffe0) == `CAF_FILTER_MODE;
  wire [2:0]  ri     = dev_addr[4:2];
  integer     i;
  // Writes, reads and the fault flag
  always @(posedge clk) begin
    if (!rst_n) begin
      regs[0] <= 32'h1;
      for (i = 1; i < 6; i = i + 1) regs[i] <= 32'h0;
      err_flag  <= 1'b0;
      err_addr  <= 32'h0;
      dev_rdata <= 32'h0;
    end else begin
      if (dev_wr && in_ram) begin
        ram[off[10:2]] <= dev_wdata;
      end else if (dev_wr && in_reg && ri < 3'h6) begin
        // Only the mode bits or the address field are held
        regs[ri] <= (ri == 3'h0) ? (dev_wdata & 32'h7) :
                    (dev_wdata & 32'hffc);
      end
      if (err_set) begin
        err_flag <= 1'b1;
        err_addr <= err_at & 32'h7fc;
      end
      if (dev_rd) begin
        dev_rdata <= in_ram ? ram[off[10:2]] :
                     (ri == 3'h6) ? err_addr :
                     (ri == 3'h7) ? {31'h0, err_flag} : regs[ri];
        // Reading the address clears the flag
        if (in_reg && ri == 3'h6 && !err_set) err_flag <= 1'b0;
      end
    end
  end
endmodule // caf_dev_model

// File: caf_host_props.sv
`timescale 1ns/1ps
`include "caf_host_map.vh"
// ==========================================
// Checker on the host ports
module caf_host_props #(
  parameter [31:0] RAM_BASE = 32'h00010000  // Lookup RAM window base
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  sw_addr,
  input  wire [31:0] sw_wdata,
  input  wire        sw_wr,
  input  wire        sw_rd,
  input  wire [31:0] sw_rdata,
  input  wire [31:0] dev_addr,
  input  wire [31:0] dev_wdata,
  input  wire        dev_wr,
  input  wire        dev_rd,
  input  wire [31:0] dev_rdata
);
  reg  [31:0] last_mode;  // Mode the filter holds now
  wire        w_at_end = dev_addr <= `CAF_TABLES_END;
  wire        is_areg  = dev_wr && dev_addr > `CAF_FILTER_MODE && w_at_end;
  wire        in_ram   = (dev_addr - RAM_BASE) < 32'h800;
  // Track mode writes; filter resets to off
  always @(posedge clk) begin
    if (!rst_n) last_mode <= 32'h1;
    else if (dev_wr && dev_addr == `CAF_FILTER_MODE) last_mode <= dev_wdata;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rst_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !dev_wr && !dev_rd) else $error("access during reset");
  a_rd_pulse: assert property (dev_rd |=> !dev_rd [*2])
    else $error("reads too close");
  a_err_order: assert property (
    dev_rd && dev_addr == `CAF_ERR_FLAG |->
    ##3 dev_rd && dev_addr == `CAF_ERR_ADDR) else $error("error read order");
  a_bypass_first: assert property (
    is_areg |-> last_mode[`CAF_BIT_BYPASS]) else $error("no bypass");
  a_cfg_seq: assert property (
    dev_wr && dev_addr == `CAF_STD_SINGLE |=>
    dev_wr && dev_addr == `CAF_STD_RANGE ##1 dev_addr == `CAF_EXT_SINGLE
    ##1 dev_addr == `CAF_EXT_RANGE ##1 dev_addr == `CAF_TABLES_END
    ##1 dev_wr && dev_addr == `CAF_FILTER_MODE) else $error("cfg order");
  a_ss_field: assert property (
    dev_wr && dev_addr == `CAF_STD_SINGLE |-> (dev_wdata & ~32'h7fc) == 0)
    else $error("single start field");
  a_rs_limit: assert property (
    dev_wr && dev_addr == `CAF_STD_RANGE |-> dev_wdata <= 32'h800)
    else $error("range start limit");
  a_es_limit: assert property (
    dev_wr && dev_addr == `CAF_EXT_SINGLE |-> dev_wdata <= 32'h800)
    else $error("ext start limit");
  a_range_dis: assert property (
    dev_wr && in_ram && !last_mode[`CAF_BIT_BYPASS] |->
    dev_wdata == 32'h0 || dev_wdata == `CAF_WORD_ALL_ONES)
    else $error("live RAM word changed");
endmodule // caf_host_props

bind caf_host caf_host_props #(.RAM_BASE(RAM_BASE)) i_caf_host_props (
  .clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
  .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
  .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
  .dev_rdata(dev_rdata));

// File: tb.sv
`timescale 1ns/1ps
`include "caf_host_map.vh"
// ==========================================
// Bench top
module tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  sw_addr = 8'h0;
  reg  [31:0] sw_wdata = 32'h0;
  reg         sw_wr = 1'b0;
  reg         sw_rd = 1'b0;
  reg         err_set = 1'b0;   // Model fault injection
  reg  [31:0] err_at = 32'h0;
  wire [31:0] sw_rdata, dev_addr, dev_wdata, dev_rdata;
  wire        dev_wr, dev_rd;
  integer     bad_count = 0;
  integer     comparisons = 0;
  reg  [31:0] kept [1:5];       // Starts and tables end the filter should hold
  reg  [2:0]  kmode = 3'h1;
  always #5 clk = ~clk;
  caf_host i_caf_host (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  caf_dev_model i_caf_dev_model (.clk(clk), .rst_n(rst_n),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_rdata(dev_rdata), .err_set(err_set),
    .err_at(err_at));
  // ========================================
  // Bus tasks
  task chk(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  // Data stands from the cycle after the strobe until the next read
  task rd(input [7:0] a, output [31:0] d);
    @(posedge clk);
    sw_addr <= a; sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // Issue a command, poll busy under a bound
  task run(input [2:0] op, output [31:0] s);
    integer n;
    wr(`CAF_H_CMD, {29'h0, op});
    s = 32'h1;
    for (n = 0; n < 40 && s[0] !== 1'b0; n = n + 1) rd(`CAF_H_STAT, s);
    if (s[0] !== 1'b0) begin
      bad_count = bad_count + 1;
      final_report;
    end
  endtask
  // ========================================
  // Scenarios
  task t_reset;
    reg [31:0] d;
    rd(`CAF_H_MODE, d); chk(d, 32'h1);
    chk(i_caf_dev_model.regs[0], 32'h1);
    rd(`CAF_H_STAT, d); chk(d, 32'h8);
    rd(8'h2c, d); chk(d, 32'h0);
  endtask
  task cfg_case(input [31:0] ss, rs, es, er, en, md, input rf);
    reg [31:0] v [1:5];
    reg [31:0] s;
    integer k;
    v[1] = ss; v[2] = rs; v[3] = es; v[4] = er; v[5] = en;
    for (k = 1; k < 6; k = k + 1) wr(8'h04 + 4 * k, v[k]);
    wr(`CAF_H_MODE, md);
    run(`CAF_OP_CFG, s);
    chk({31'h0, s[1]}, {31'h0, rf});
    if (!rf) kmode = md[2:0];
    for (k = 1; k < 6; k = k + 1) begin
      if (!rf) kept[k] = v[k];
      chk(i_caf_dev_model.regs[k], kept[k]);
    end
    chk(i_caf_dev_model.regs[0], {29'h0, kmode});
    chk({29'h0, s[5:3]}, {29'h0, kmode});
  endtask
  task t_cfg;
    cfg_case(32'h40, 32'h60, 32'h900, 32'h900, 32'h900, 32'h08, 1);
    cfg_case(32'h40, 32'h60, 32'h70, 32'h100, 32'h104, 32'h10, 1);
    cfg_case(32'h40, 32'h40, 32'h40, 32'h100, 32'h110, 32'h08, 1);
    cfg_case(32'h40, 32'h60, 32'h70, 32'h100, 32'h700, 32'h0c, 1);
    cfg_case(32'h40, 32'h60, 32'h70, 32'h70, 32'h70, 32'h08, 0);
    cfg_case(32'h40, 32'h60, 32'h70, 32'h100, 32'h110, 32'h0d, 0);
    cfg_case(32'h40, 32'h60, 32'h70, 32'h100, 32'h110, 32'h0a, 0);
    cfg_case(32'h40, 32'h60, 32'h70, 32'h100, 32'h110, 32'h08, 0);
  endtask
  // One word write or range toggle, then verdict
  task word_case(input [2:0] op, input [8:0] ix, input [31:0] d,
                 input rf, input [31:0] exp);
    reg [31:0] s;
    wr(`CAF_H_RIDX, {23'h0, ix});
    wr(`CAF_H_RDAT, d);
    run(op, s);
    chk({31'h0, s[1]}, {31'h0, rf});
    chk(i_caf_dev_model.ram[ix], exp);
    chk(i_caf_dev_model.regs[0], {29'h0, kmode});
  endtask
  task t_words;
    word_case(`CAF_OP_RAM, 9'h1ff, 32'h12345678, 0, 32'h12345678);
    word_case(`CAF_OP_RAM, 9'h01c, 32'ha5a5a5a5, 0, 32'ha5a5a5a5);
    word_case(`CAF_OP_DIS, 9'h01b, 32'h0, 0, 32'hffffffff);
    word_case(`CAF_OP_ENA, 9'h018, 32'h0, 0, 32'h0);
    word_case(`CAF_OP_ENA, 9'h01c, 32'h0, 1, 32'ha5a5a5a5);
  endtask
  task t_err;
    reg [31:0] s;
    @(posedge clk);
    err_set <= 1'b1; err_at <= 32'h1a4;
    @(posedge clk);
    err_set <= 1'b0;
    run(`CAF_OP_ERR, s);
    chk({31'h0, s[2]}, 32'h1);
    rd(`CAF_H_ERRAD, s); chk(s, 32'h1a4);
    chk({31'h0, i_caf_dev_model.err_flag}, 32'h0);
  endtask
  // Main sequence
  initial begin
    kept[1] = 0; kept[2] = 0; kept[3] = 0; kept[4] = 0; kept[5] = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_cfg;
    t_words;
    t_err;
    final_report;
  end
endmodule // tb
